// ### logic/slt_pkg.sv
// shared constants and types of the spi link tunnel
package slt_pkg;

  // ************************************************************
  // mode selection
  // ************************************************************
  localparam logic [2:0] SLT_MODE_FWD = 3'h6;  // forward channel tunnel
  localparam logic [2:0] SLT_MODE_REV = 3'h7;  // reverse channel tunnel

  typedef enum logic [1:0] {
    SLT_OFF = 2'b00,
    SLT_FWD = 2'b01,
    SLT_REV = 2'b10
  } slt_mode_t;

  // ************************************************************
  // forward frame bit positions
  // ************************************************************
  localparam int SLT_FWD_BITS = 3;
  localparam int SLT_BIT_SS   = 0;
  localparam int SLT_BIT_MOSI = 1;
  localparam int SLT_BIT_SCLK = 2;

  // ************************************************************
  // idle levels of the regenerated lines
  // ************************************************************
  localparam logic SLT_IDLE_SS_N = 1'b1;
  localparam logic SLT_IDLE_SCLK = 1'b0;
  localparam logic SLT_IDLE_MOSI = 1'b0;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int SLT_MCLK_PERIOD_PS = 5000;
  localparam int SLT_REGEN_HALF_PS  = 20000;  // least half period
  localparam int SLT_REGEN_CYC =
    (SLT_REGEN_HALF_PS + SLT_MCLK_PERIOD_PS - 1) / SLT_MCLK_PERIOD_PS;
  localparam int SLT_BC_FRAME_CYC = 32;       // link clocks per frame
  localparam int SLT_FIFO_DEPTH   = 16;

  // reverse regeneration sequence
  typedef enum logic [1:0] {
    SLT_RG_IDLE  = 2'b00,
    SLT_RG_SETUP = 2'b01,
    SLT_RG_HIGH  = 2'b10
  } slt_rg_t;

endpackage : slt_pkg

// ### logic/slt_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module slt_fifo
  import slt_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter int DEPTH = SLT_FIFO_DEPTH
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // honest full and empty straight from the count
  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_r];

  // storage, no reset needed for the data words
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // pointers and fill level
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_level: assert property (@(posedge mclk) disable iff (!rstn)
    inValid && !inReady && !outReady |=> $stable(count_r))
    else $error("fifo level moved while full and stalled");

endmodule : slt_fifo

// ### logic/slt_tunnel.sv
// spi tunnel over the secondary lane: sampling, framing, regeneration
`timescale 1ns/1ps
module slt_tunnel
  import slt_pkg::*;
#(
  parameter int FIFO_DEPTH   = SLT_FIFO_DEPTH,
  parameter int BC_FRAME_CYC = SLT_BC_FRAME_CYC
) (
  input  wire logic                    mclk,
  input  wire logic                    rstn,
  input  wire logic                    linkClk,
  input  wire logic [2:0]              sideChannelMode,
  input  wire logic                    linkLocked,
  input  wire logic                    twoLane,
  input  wire logic                    pinSclk,
  input  wire logic                    pinMosi,
  input  wire logic                    pinSsN,
  output logic [SLT_FWD_BITS-1:0]      fwdFrameBits,
  input  wire logic [SLT_FWD_BITS-1:0] fwdRxBits,
  output logic                         bcFrameStrobe,
  output logic                         bcFrameSsN,
  output logic                         bcFrameValid,
  output logic                         bcFrameData,
  input  wire logic                    bcRxStrobe,
  input  wire logic                    bcRxSsN,
  input  wire logic                    bcRxValid,
  input  wire logic                    bcRxData,
  output logic                         regenSclk,
  output logic                         regenMosi,
  output logic                         regenSsN,
  output logic                         captureOverflow
);

  // ************************************************************
  // mode decode
  // ************************************************************
  function automatic slt_mode_t decodeMode(input logic [2:0] fld,
                                           input logic       lock,
                                           input logic       lanes);
    slt_mode_t m;
    m = SLT_OFF;
    if (lock && lanes && fld == SLT_MODE_FWD) begin
      m = SLT_FWD;
    end else if (lock && lanes && fld == SLT_MODE_REV) begin
      m = SLT_REV;
    end
    return m;
  endfunction : decodeMode

  slt_mode_t mode_r;

  // registered so the datapath never sees a glitching mode
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= SLT_OFF;
    end else begin
      mode_r <= decodeMode(sideChannelMode, linkLocked, twoLane);
    end
  end

  // ************************************************************
  // pin synchronisers in the pixel/oscillator domain
  // ************************************************************
  logic [SLT_FWD_BITS-1:0] pinRaw;
  logic [SLT_FWD_BITS-1:0] sync1_r;
  logic [SLT_FWD_BITS-1:0] sync2_r;
  logic [SLT_FWD_BITS-1:0] sync3_r;
  logic [SLT_FWD_BITS-1:0] pinStable_r;

  assign pinRaw = {pinSclk, pinMosi, pinSsN};

  // three stages; the master owns these levels
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= {SLT_IDLE_SCLK, SLT_IDLE_MOSI, SLT_IDLE_SS_N};
      sync2_r <= {SLT_IDLE_SCLK, SLT_IDLE_MOSI, SLT_IDLE_SS_N};
      sync3_r <= {SLT_IDLE_SCLK, SLT_IDLE_MOSI, SLT_IDLE_SS_N};
    end else begin
      sync1_r <= pinRaw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // a change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < SLT_FWD_BITS; gi++) begin : g_filt
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          pinStable_r[gi] <= (gi == SLT_BIT_SS) ? SLT_IDLE_SS_N : 1'b0;
        end else if (sync2_r[gi] == sync3_r[gi]) begin
          pinStable_r[gi] <= sync3_r[gi];
        end
      end
    end
  endgenerate

  // ************************************************************
  // forward channel sampling
  // ************************************************************
  // every pixel clock is a sample; no spi clock edge is used
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fwdFrameBits <= {SLT_IDLE_SCLK, SLT_IDLE_MOSI, SLT_IDLE_SS_N};
    end else if (mode_r == SLT_FWD) begin
      fwdFrameBits <= pinStable_r;
    end else begin
      fwdFrameBits <= {SLT_IDLE_SCLK, SLT_IDLE_MOSI, SLT_IDLE_SS_N};
    end
  end

  // ************************************************************
  // reverse channel capture and queueing
  // ************************************************************
  logic sclkPrev_r;
  logic sclkRise;
  logic capValid;
  logic capReady;
  logic qValid;
  logic qReady;
  logic qData;

  assign sclkRise = pinStable_r[SLT_BIT_SCLK] && !sclkPrev_r;
  assign capValid = (mode_r == SLT_REV) && sclkRise;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclkPrev_r <= SLT_IDLE_SCLK;
    end else begin
      sclkPrev_r <= pinStable_r[SLT_BIT_SCLK];
    end
  end

  // a full queue cannot stall the master; flag the lost bit instead
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      captureOverflow <= 1'b0;
    end else if (mode_r == SLT_OFF) begin
      captureOverflow <= 1'b0;
    end else if (capValid && !capReady) begin
      captureOverflow <= 1'b1;
    end
  end

  slt_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .rstn     (rstn),
    .inValid  (capValid),
    .inReady  (capReady),
    .inData   (pinStable_r[SLT_BIT_MOSI]),
    .outValid (qValid),
    .outReady (qReady),
    .outData  (qData)
  );

  // ************************************************************
  // word crossing into the link domain by toggle handshake
  // ************************************************************
  logic hsReq_r;
  logic hsData_r;
  logic hsPending_r;
  logic ackS1_r;
  logic ackS2_r;
  logic ackS3_r;
  logic reqSeen_r;

  // one word in flight keeps the queue as the only buffer
  assign qReady = !hsPending_r;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hsReq_r     <= 1'b0;
      hsData_r    <= 1'b0;
      hsPending_r <= 1'b0;
    end else if (qValid && !hsPending_r) begin
      hsReq_r     <= !hsReq_r;
      hsData_r    <= qData;
      hsPending_r <= 1'b1;
    end else if (hsPending_r && ackS2_r == ackS3_r && ackS3_r == hsReq_r) begin
      hsPending_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ackS1_r <= 1'b0;
      ackS2_r <= 1'b0;
      ackS3_r <= 1'b0;
    end else begin
      ackS1_r <= reqSeen_r;
      ackS2_r <= ackS1_r;
      ackS3_r <= ackS2_r;
    end
  end

  // ************************************************************
  // back channel framing on the link clock
  // ************************************************************
  localparam int FCW = $clog2(BC_FRAME_CYC);

  logic           reqS1_r;
  logic           reqS2_r;
  logic           reqS3_r;
  logic           ssL1_r;
  logic           ssL2_r;
  logic           ssL3_r;
  logic           ssLink_r;
  logic [FCW-1:0] frameCnt_r;
  logic           reqNew;

  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      reqS1_r <= 1'b0;
      reqS2_r <= 1'b0;
      reqS3_r <= 1'b0;
      ssL1_r  <= SLT_IDLE_SS_N;
      ssL2_r  <= SLT_IDLE_SS_N;
      ssL3_r  <= SLT_IDLE_SS_N;
    end else begin
      reqS1_r <= hsReq_r;
      reqS2_r <= reqS1_r;
      reqS3_r <= reqS2_r;
      ssL1_r  <= pinStable_r[SLT_BIT_SS];
      ssL2_r  <= ssL1_r;
      ssL3_r  <= ssL2_r;
    end
  end

  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      ssLink_r <= SLT_IDLE_SS_N;
    end else if (ssL2_r == ssL3_r) begin
      ssLink_r <= ssL3_r;
    end
  end

  assign reqNew = (reqS2_r == reqS3_r) && (reqS3_r != reqSeen_r);

  // frame timer; the link clock runs free
  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      frameCnt_r <= '0;
    end else if (frameCnt_r == FCW'(BC_FRAME_CYC - 1)) begin
      frameCnt_r <= '0;
    end else begin
      frameCnt_r <= frameCnt_r + 1'b1;
    end
  end

  // one frame per timer wrap, select always, one sample at most
  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      bcFrameStrobe <= 1'b0;
      bcFrameSsN    <= SLT_IDLE_SS_N;
      bcFrameValid  <= 1'b0;
      bcFrameData   <= 1'b0;
      reqSeen_r     <= 1'b0;
    end else if (frameCnt_r == '0) begin
      bcFrameStrobe <= 1'b1;
      bcFrameSsN    <= ssLink_r;
      bcFrameValid  <= reqNew;
      bcFrameData   <= reqNew ? hsData_r : 1'b0;
      if (reqNew) begin
        reqSeen_r <= reqS3_r;
      end
    end else begin
      bcFrameStrobe <= 1'b0;
      bcFrameValid  <= 1'b0;
    end
  end

  // ************************************************************
  // regeneration at the far end
  // ************************************************************
  localparam int RCW = $clog2(SLT_REGEN_CYC + 1);

  slt_rg_t        rgState_r;
  logic [RCW-1:0] rgCnt_r;
  logic           rgData_r;
  logic           rgSsN_r;
  logic           sclkDly_r;

  // each sample arriving while idle makes one clock pulse, one arriving mid-pulse is dropped; at most one pulse per back frame
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rgState_r <= SLT_RG_IDLE;
      rgCnt_r   <= '0;
      rgData_r  <= SLT_IDLE_MOSI;
      rgSsN_r   <= SLT_IDLE_SS_N;
    end else if (mode_r != SLT_REV) begin
      rgState_r <= SLT_RG_IDLE;
      rgCnt_r   <= '0;
      rgSsN_r   <= SLT_IDLE_SS_N;
    end else begin
      if (bcRxStrobe) begin
        rgSsN_r <= bcRxSsN;
      end
      case (rgState_r)
        SLT_RG_IDLE: begin
          if (bcRxStrobe && bcRxValid) begin
            rgData_r  <= bcRxData;
            rgCnt_r   <= RCW'(SLT_REGEN_CYC - 1);
            rgState_r <= SLT_RG_SETUP;
          end
        end
        SLT_RG_SETUP: begin
          if (rgCnt_r == '0) begin
            rgCnt_r   <= RCW'(SLT_REGEN_CYC - 1);
            rgState_r <= SLT_RG_HIGH;
          end else begin
            rgCnt_r <= rgCnt_r - 1'b1;
          end
        end
        SLT_RG_HIGH: begin
          if (rgCnt_r == '0) begin
            rgState_r <= SLT_RG_IDLE;
          end else begin
            rgCnt_r <= rgCnt_r - 1'b1;
          end
        end
        default: begin
          rgState_r <= SLT_RG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclkDly_r <= SLT_IDLE_SCLK;
    end else begin
      sclkDly_r <= fwdRxBits[SLT_BIT_SCLK];
    end
  end

  // forward mode: clock takes one more stage than data for a cycle of setup
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      regenSclk <= SLT_IDLE_SCLK;
      regenMosi <= SLT_IDLE_MOSI;
      regenSsN  <= SLT_IDLE_SS_N;
    end else begin
      case (mode_r)
        SLT_FWD: begin
          regenSclk <= sclkDly_r;
          if (!sclkDly_r) begin
            regenMosi <= fwdRxBits[SLT_BIT_MOSI];
          end
          regenSsN <= fwdRxBits[SLT_BIT_SS];
        end
        SLT_REV: begin
          regenSclk <= (rgState_r == SLT_RG_HIGH);
          regenMosi <= rgData_r;
          regenSsN  <= rgSsN_r;
        end
        default: begin
          regenSclk <= SLT_IDLE_SCLK;
          regenMosi <= SLT_IDLE_MOSI;
          regenSsN  <= SLT_IDLE_SS_N;
        end
      endcase
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  a_fwd_frame_bits: assert property (@(posedge mclk) disable iff (!rstn)
    mode_r == SLT_FWD |=> fwdFrameBits == $past(pinStable_r))
    else $error("forward frame does not carry latest samples");

  a_fwd_clk_lag: assert property (@(posedge mclk) disable iff (!rstn)
    mode_r == SLT_FWD ##1 mode_r == SLT_FWD
      |=> regenSclk == $past(fwdRxBits[SLT_BIT_SCLK], 2))
    else $error("regenerated clock not two stages behind");

  a_fwd_mosi_hold: assert property (@(posedge mclk) disable iff (!rstn)
    mode_r == SLT_FWD && $past(mode_r) == SLT_FWD
      && regenSclk && $past(regenSclk) |-> $stable(regenMosi))
    else $error("data moved while regenerated clock high");

  a_idle_levels: assert property (@(posedge mclk) disable iff (!rstn)
    mode_r == SLT_OFF |=> regenSsN && !regenSclk && !regenMosi)
    else $error("regenerated lines not idle while disabled");

  // judged bit by bit: another pin may still be settling in that cycle
  a_sync_agree: assert property (@(posedge mclk) disable iff (!rstn)
    $changed(pinStable_r) |-> &(~($past(sync2_r) ^ $past(sync3_r))
      | ~($past(pinStable_r) ^ pinStable_r)))
    else $error("pin level taken before stages agreed");

  a_rev_capture: assert property (@(posedge mclk) disable iff (!rstn)
    capValid == (mode_r == SLT_REV && $rose(pinStable_r[SLT_BIT_SCLK])))
    else $error("capture not matching reverse mode clock edge");

  a_rev_burst: assert property (@(posedge mclk) disable iff (!rstn)
    rgState_r == SLT_RG_SETUP && $past(rgState_r) == SLT_RG_IDLE
      |-> (rgState_r == SLT_RG_SETUP) [*4] ##1 rgState_r == SLT_RG_HIGH)
    else $error("regenerated pulse setup length wrong");

  a_frame_single: assert property (@(posedge linkClk) disable iff (!rstn)
    bcFrameStrobe |=> !bcFrameValid && !bcFrameStrobe)
    else $error("more than one sample in a back frame");

  a_frame_select: assert property (@(posedge linkClk) disable iff (!rstn)
    bcFrameStrobe |-> bcFrameSsN == $past(ssLink_r))
    else $error("back frame missing select state");

  c_fwd_clock: cover property (@(posedge mclk) disable iff (!rstn)
    mode_r == SLT_FWD && $rose(regenSclk));

  c_rev_frame: cover property (@(posedge linkClk) disable iff (!rstn)
    bcFrameStrobe && bcFrameValid);

  c_rev_pulse: cover property (@(posedge mclk) disable iff (!rstn)
    rgState_r == SLT_RG_HIGH);

  c_overflow: cover property (@(posedge mclk) disable iff (!rstn)
    $rose(captureOverflow));

endmodule : slt_tunnel

// ### testbench/slt_spi_master.sv
// behavioural spi master driving the tunnel's pins
`timescale 1ns/1ps
module slt_spi_master #(
  parameter int GAP = 120
) (
  input  wire logic mclk,
  output logic      sclk,
  output logic      mosi,
  output logic      ssN
);
  // ********
  // idle levels and transfers
  // ********
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    ssN  = 1'b1;
  end

  // static levels, only while no frame runs
  task automatic drive(input logic [2:0] lv);
    {sclk, mosi, ssN} = lv;
  endtask : drive

  // mode 0 frame, msb first; a long half period gives reads
  // the room they need for the round trip
  task automatic send(input logic [31:0] dat, input int nb,
                      input int half);
    @(posedge mclk);
    #1;
    ssN = 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      mosi = dat[i];
      repeat (half) @(posedge mclk);
      #1;
      sclk = 1'b1;
      repeat (half) @(posedge mclk);
      #1;
      sclk = 1'b0;
    end
    repeat (half) @(posedge mclk);
    #1;
    ssN  = 1'b1;
    mosi = ~mosi;  // released line must not keep the last bit
    // select stays high longer than one back frame
    repeat (GAP) @(posedge mclk);
  endtask : send
endmodule : slt_spi_master

// ### testbench/slt_tunnel_tb.sv
// self-checking bench of the spi link tunnel
`timescale 1ns/1ps
module slt_tunnel_tb
  import slt_pkg::*;
;
  typedef struct packed {
    logic [2:0] mode, pin, rx, expF, expR;
    logic       lk, tl;
  } slt_row_t;
  // steady levels: fields mode, pins, rx, frame, regen, lock, lanes
  localparam slt_row_t ROWS [7] = '{
    '{3'h6, 3'h6, 3'h6, 3'h6, 3'h4, 1'b1, 1'b1},
    '{3'h6, 3'h3, 3'h3, 3'h3, 3'h3, 1'b1, 1'b1},
    '{3'h6, 3'h6, 3'h6, 3'h1, 3'h1, 1'b0, 1'b1},
    '{3'h6, 3'h6, 3'h6, 3'h1, 3'h1, 1'b1, 1'b0},
    '{3'h7, 3'h6, 3'h6, 3'h1, 3'h1, 1'b1, 1'b1},
    '{3'h0, 3'h6, 3'h6, 3'h1, 3'h1, 1'b1, 1'b1},
    '{3'h5, 3'h6, 3'h6, 3'h1, 3'h1, 1'b1, 1'b1}};

  logic       mclk, rstn, linkClk, linkLocked, twoLane, loopOn;
  logic [2:0] mode, rxDrv, fwdFrameBits, fwdRxBits;
  logic       pinSclk, pinMosi, pinSsN, pS, rS, sawLow;
  logic       bcFrameStrobe, bcFrameSsN, bcFrameValid, bcFrameData;
  logic       bcRxStrobe, bcRxSsN, bcRxValid, bcRxData;
  logic       regenSclk, regenMosi, regenSsN, captureOverflow, m;
  logic [7:0] fwdByte, rgByte, revByte;
  int         error_cnt, compares, cyc, hi;
  int         fwdCnt, rgCnt, revCnt, badVal;

  // loop lets the forward frame feed the regenerating side
  assign fwdRxBits = loopOn ? fwdFrameBits : rxDrv;

  slt_tunnel #(.FIFO_DEPTH(16), .BC_FRAME_CYC(8)) slt_tunnel_inst (
    .mclk(mclk), .rstn(rstn), .linkClk(linkClk),
    .sideChannelMode(mode), .linkLocked(linkLocked),
    .twoLane(twoLane), .pinSclk(pinSclk), .pinMosi(pinMosi),
    .pinSsN(pinSsN), .fwdFrameBits(fwdFrameBits),
    .fwdRxBits(fwdRxBits), .bcFrameStrobe(bcFrameStrobe),
    .bcFrameSsN(bcFrameSsN), .bcFrameValid(bcFrameValid),
    .bcFrameData(bcFrameData), .bcRxStrobe(bcRxStrobe),
    .bcRxSsN(bcRxSsN), .bcRxValid(bcRxValid), .bcRxData(bcRxData),
    .regenSclk(regenSclk), .regenMosi(regenMosi),
    .regenSsN(regenSsN), .captureOverflow(captureOverflow));

  slt_spi_master #(.GAP(120)) slt_spi_master_inst (
    .mclk(mclk), .sclk(pinSclk), .mosi(pinMosi), .ssN(pinSsN));

  // ********
  // clocks, monitors, timeout
  // ********
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    linkClk = 1'b0;
    #7.3;
    forever #32 linkClk = ~linkClk;
  end

  // bits seen at each rising clock, on frame and on regen side
  always @(posedge mclk) begin
    pS <= fwdFrameBits[SLT_BIT_SCLK];
    rS <= regenSclk;
    if (fwdFrameBits[SLT_BIT_SCLK] && !pS) begin
      fwdByte <= {fwdByte[6:0], fwdFrameBits[SLT_BIT_MOSI]};
      fwdCnt  <= fwdCnt + 1;
    end
    if (regenSclk && !rS) begin
      rgByte <= {rgByte[6:0], regenMosi};
      rgCnt  <= rgCnt + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // back frames: samples, stray valids, select state
  always @(posedge linkClk) begin
    if (bcFrameValid && !bcFrameStrobe) badVal <= badVal + 1;
    if (bcFrameStrobe && bcFrameValid) begin
      revByte <= {revByte[6:0], bcFrameData};
      revCnt  <= revCnt + 1;
    end
    if (bcFrameStrobe && !bcFrameSsN) sawLow <= 1'b1;
  end

  // ********
  // tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic clr();
    fwdCnt = 0;
    rgCnt  = 0;
    revCnt = 0;
    badVal = 0;
    sawLow = 1'b0;
  endtask : clr

  // one received back frame, strobe for a single cycle
  task automatic rxFrame(input logic ss, v, d);
    @(posedge mclk);
    #1;
    bcRxStrobe = 1'b1;
    bcRxSsN    = ss;
    bcRxValid  = v;
    bcRxData   = d;
    @(posedge mclk);
    #1;
    bcRxStrobe = 1'b0;
    bcRxValid  = 1'b0;
  endtask : rxFrame

  task automatic report_and_stop();
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // ********
  // main sequence
  // ********
  initial begin
    {mode, linkLocked, twoLane, loopOn} = 6'h00;
    {bcRxStrobe, bcRxSsN, bcRxValid, bcRxData} = 4'h4;
    {error_cnt, compares, cyc} = '0;
    rxDrv = 3'h1;
    rstn  = 1'b0;
    clr();
    repeat (5) @(posedge linkClk);
    #1;
    chk("rst", {fwdFrameBits, regenSclk, regenMosi, regenSsN, bcFrameSsN,
        bcFrameStrobe, bcFrameValid, captureOverflow}, 10'h098);
    @(posedge mclk);
    #1;
    rstn = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    foreach (ROWS[i]) begin
      linkLocked = ROWS[i].lk;
      twoLane    = ROWS[i].tl;
      mode       = ROWS[i].mode;
      rxDrv      = ROWS[i].rx;
      slt_spi_master_inst.drive(ROWS[i].pin);
      repeat (12) @(posedge mclk);
      #1;
      chk("frame", fwdFrameBits, ROWS[i].expF);
      chk("regen", {regenSclk, regenMosi, regenSsN}, ROWS[i].expR);
    end
    // forward regen: clock lags data, data held while clock high
    linkLocked = 1'b1;
    mode  = SLT_MODE_FWD;
    rxDrv = 3'h2;
    slt_spi_master_inst.drive(3'h1);
    repeat (6) @(posedge mclk);
    #1;
    rxDrv = 3'h6;
    @(posedge mclk);
    #1;
    chk("lagSclk", regenSclk, 1'b0);
    rxDrv = 3'h4;
    repeat (2) begin
      @(posedge mclk);
      #1;
      chk("holdMosi", {regenSclk, regenMosi}, 2'h3);
    end
    rxDrv = 3'h0;
    repeat (6) @(posedge mclk);
    #1;
    chk("relMosi", {regenSclk, regenMosi}, 2'h0);
    // whole byte: pins to frame, looped back to regen lines
    loopOn = 1'b1;
    clr();
    slt_spi_master_inst.send(32'h3c, 8, 4);
    chk("fwdByte", {fwdCnt[7:0], fwdByte}, 16'h083c);
    chk("rgByte", {rgCnt[7:0], rgByte}, 16'h083c);
    // reverse capture drained one sample per back frame; the slow
    // clock keeps select low across several frames so one sees it
    loopOn = 1'b0;
    mode = SLT_MODE_REV;
    clr();
    slt_spi_master_inst.send(32'ha5, 8, 16);
    for (int i = 0; i < 300 && revCnt < 8; i++) @(posedge linkClk);
    repeat (20) @(posedge linkClk);
    #1;
    chk("revByte", {revCnt[7:0], revByte}, 16'h08a5);
    chk("oneEach", badVal, 0);
    chk("ssFrames", {sawLow, bcFrameSsN}, 2'h3);
    // long burst overflows the 16-word queue; mode off clears
    slt_spi_master_inst.send(32'h5a5a5a5a, 32, 4);
    chk("ovf", captureOverflow, 1'b1);
    mode = 3'h0;
    repeat (6) @(posedge mclk);
    #1;
    chk("ovfClr", captureOverflow, 1'b0);
    // reverse regen: select, pulse width, busy sample ignored
    mode = SLT_MODE_REV;
    rxFrame(1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge mclk);
    #1;
    chk("revSs", regenSsN, 1'b0);
    rxFrame(1'b0, 1'b1, 1'b1);
    rxFrame(1'b0, 1'b1, 1'b0);
    hi = 0;
    for (int i = 0; i < 20; i++) begin
      @(posedge mclk);
      #1;
      if (regenSclk === 1'b1) hi++;
      if (hi == 1) m = regenMosi;
    end
    chk("pulse", hi, SLT_REGEN_CYC);
    chk("pulseMosi", {m, regenMosi}, 2'h3);
    rxFrame(1'b0, 1'b1, 1'b0);
    repeat (12) @(posedge mclk);
    #1;
    chk("nextMosi", regenMosi, 1'b0);
    rxFrame(1'b1, 1'b0, 1'b0);
    repeat (3) @(posedge mclk);
    #1;
    chk("revSsOff", regenSsN, 1'b1);
    report_and_stop();
  end
endmodule : slt_tunnel_tb
